// *** hdl/nmirim_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module nmirim_core #(
    parameter int XLEN    = 32,
    parameter int N_EXTRA = 2,
    parameter int N_IRQ   = 4 + N_EXTRA
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // pipeline events
    input  wire logic               nmi_take,
    input  wire logic               mret_exec,
    input  wire logic [XLEN-1:0]    cur_pc,
    input  wire logic [XLEN-1:0]    mepc,
    input  wire logic [1:0]         cur_priv,
    input  wire logic               cur_mie,
    input  wire logic               cur_mpie,
    input  wire logic [1:0]         cur_mpp,
    input  wire logic [XLEN-1:0]    mtvec,
    input  wire logic               nmi_vec_sel,
    input  wire logic [XLEN-1:0]    reset_vector,
    // basic-mode enables and sources
    input  wire logic [N_IRQ-1:0]   irq_enable,
    input  wire logic               plat_ext_irq,
    input  wire logic               msw_req,
    input  wire logic               ssw_req,
    input  wire logic               timer_req,
    input  wire logic [N_EXTRA-1:0] extra_req,
    // enhanced controller request
    input  wire logic               enh_irq,
    // redirect and status out
    output logic                    redirect,
    output logic [XLEN-1:0]         redirect_pc,
    output logic                    status_wr,
    output logic                    new_mie,
    output logic                    new_mpie,
    output logic [1:0]              new_priv,
    output logic [1:0]              new_mpp,
    output logic [XLEN-1:0]         saved_epc,
    output logic [1:0]              machine_submode_now,
    output logic [1:0]              machine_submode_prior,
    output logic                    enh_mode,
    output logic [N_IRQ-1:0]        irq_pending,
    output logic                    irq_to_core
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // synchroniser stages for the asynchronous request lines
        logic [N_IRQ-1:0] raw_meta;
        logic [N_IRQ-1:0] raw_sync;
        logic             enh_meta;
        logic             enh_sync;
        // redirect and status write-back toward the pipeline
        logic             redirect;
        logic [XLEN-1:0]  redirect_pc;
        logic             status_wr;
        logic             new_mie;
        logic             new_mpie;
        logic [1:0]       new_priv;
        logic [1:0]       new_mpp;
        logic [XLEN-1:0]  saved_epc;
        // sub-mode pair
        logic [1:0]       sub_now;
        logic [1:0]       sub_prior;
        // interrupt mode and masking
        logic             enh_mode;
        logic [N_IRQ-1:0] pend;
        logic             irq;
    } nmirim_state_s;

    nmirim_state_s st;
    nmirim_state_s next_st;

    // ------------------------------------------------------------
    // request lines and trap events
    // ------------------------------------------------------------
    logic [N_IRQ-1:0] raw_req;
    logic             trap_enter;
    logic             trap_leave;

    // bit order matches the mie layout: msw, timer, ext, ssw, extras
    assign raw_req = {extra_req,
                      ssw_req,
                      plat_ext_irq,
                      timer_req,
                      msw_req};

    // nmi cannot be masked, so it wins over an mret in the same cycle
    assign trap_enter = nmi_take;
    assign trap_leave = mret_exec & ~nmi_take;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // nmi vector is shared with mtvec or taken from the reset vector
    function automatic logic [XLEN-1:0] nmi_vector(
        input logic            sel,
        input logic [XLEN-1:0] tv,
        input logic [XLEN-1:0] rv
    );
        nmi_vector = sel ? tv : rv;
    endfunction

    // the mode field sits in the low bits of mtvec
    function automatic logic mode_is_enhanced(
        input logic [XLEN-1:0] tv
    );
        logic [1:0] mode_bits;
        mode_bits = tv[nmirim_pkg::MTVEC_MODE_LO +: 2];
        mode_is_enhanced = (mode_bits == nmirim_pkg::MODE_CLIC);
    endfunction

    // per-source gate: each line counts only with its own enable bit
    function automatic logic [N_IRQ-1:0] gate_sources(
        input logic [N_IRQ-1:0] req,
        input logic [N_IRQ-1:0] en
    );
        logic [N_IRQ-1:0] g;
        g = '0;
        g[nmirim_pkg::IRQ_MSI] = req[nmirim_pkg::IRQ_MSI]
                                 & en[nmirim_pkg::IRQ_MSI];
        g[nmirim_pkg::IRQ_MTI] = req[nmirim_pkg::IRQ_MTI]
                                 & en[nmirim_pkg::IRQ_MTI];
        // one enable covers every source behind the platform controller
        g[nmirim_pkg::IRQ_MEI] = req[nmirim_pkg::IRQ_MEI]
                                 & en[nmirim_pkg::IRQ_MEI];
        // supervisor software and extra internal lines each own a bit
        for (int i = nmirim_pkg::IRQ_FIXED; i < N_IRQ; i++) begin
            g[i] = req[i] & en[i];
        end
        gate_sources = g;
    endfunction

    // global gate: the machine enable masks every machine interrupt
    function automatic logic gate_global(
        input logic req,
        input logic mie_bit
    );
        gate_global = req & mie_bit;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // only the second stage feeds logic; the first may be metastable
        next_st.raw_meta  = raw_req;
        next_st.raw_sync  = st.raw_meta;
        next_st.enh_meta  = enh_irq;
        next_st.enh_sync  = st.enh_meta;

        // one-cycle pulses drop unless an event raises them again
        next_st.redirect  = 1'b0;
        next_st.status_wr = 1'b0;

        // reset mtvec has clear mode bits, so basic mode comes first
        next_st.enh_mode  = mode_is_enhanced(mtvec);

        // basic mode: mie bits gate internal lines and the platform line
        next_st.pend = gate_sources(st.raw_sync, irq_enable);

        if (st.enh_mode) begin
            // mie and mip are bypassed: the controller already gated it
            next_st.irq = gate_global(st.enh_sync, cur_mie);
        end else begin
            // a pending line is already past its own enable
            next_st.irq = gate_global(|st.pend, cur_mie);
        end

        // sub-mode, mie, privilege and pc are stacked; software keeps its own context
        if (trap_enter) begin
            next_st.redirect    = 1'b1;
            next_st.redirect_pc = nmi_vector(nmi_vec_sel, mtvec,
                                             reset_vector);
            next_st.saved_epc   = cur_pc;
            next_st.status_wr   = 1'b1;
            next_st.new_mpie    = cur_mie;
            next_st.new_mie     = 1'b0;
            next_st.new_mpp     = cur_priv;
            next_st.new_priv    = nmirim_pkg::PRIV_M;
            next_st.sub_prior   = st.sub_now;
            next_st.sub_now     = nmirim_pkg::SUBM_NMI;
        end else if (trap_leave) begin
            next_st.redirect    = 1'b1;
            next_st.redirect_pc = mepc;
            next_st.status_wr   = 1'b1;
            next_st.new_mie     = cur_mpie;
            next_st.new_mpie    = 1'b1;
            next_st.new_priv    = cur_mpp;
            next_st.new_mpp     = 2'h0;
            next_st.sub_now     = st.sub_prior;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset keeps basic mode, machine privilege and normal sub-mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // synchronisers
            st.raw_meta    <= '0;
            st.raw_sync    <= '0;
            st.enh_meta    <= 1'b0;
            st.enh_sync    <= 1'b0;
            // write-back
            st.redirect    <= 1'b0;
            st.redirect_pc <= '0;
            st.status_wr   <= 1'b0;
            st.new_mie     <= 1'b0;
            st.new_mpie    <= 1'b0;
            st.new_priv    <= nmirim_pkg::PRIV_M;
            st.new_mpp     <= 2'h0;
            st.saved_epc   <= '0;
            // sub-mode and interrupt state
            st.sub_now     <= nmirim_pkg::RST_SUBM;
            st.sub_prior   <= nmirim_pkg::RST_SUBM;
            st.enh_mode    <= 1'b0;
            st.pend        <= '0;
            st.irq         <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // write-back toward the pipeline
    assign redirect              = st.redirect;
    assign redirect_pc           = st.redirect_pc;
    assign status_wr             = st.status_wr;
    assign new_mie               = st.new_mie;
    assign new_mpie              = st.new_mpie;
    assign new_priv              = st.new_priv;
    assign new_mpp               = st.new_mpp;
    assign saved_epc             = st.saved_epc;
    // sub-mode, mode and interrupt state
    assign machine_submode_now   = st.sub_now;
    assign machine_submode_prior = st.sub_prior;
    assign enh_mode              = st.enh_mode;
    assign irq_pending           = st.pend;
    assign irq_to_core           = st.irq;
endmodule
`default_nettype wire

// *** hdl/nmirim_pkg.sv ***
package nmirim_pkg;
    // ------------------------------------------------------------
    // sub-mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SUBM_NORMAL = 2'h0;
    localparam logic [1:0] SUBM_INTR   = 2'h1;
    localparam logic [1:0] SUBM_EXCP   = 2'h2;
    localparam logic [1:0] SUBM_NMI    = 2'h3;
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] PRIV_M        = 2'h3;
    localparam logic [1:0] RST_SUBM      = 2'h0;
    localparam logic [1:0] MODE_CLIC     = 2'h3;
    localparam int         MTVEC_MODE_LO = 0;
    localparam int         IRQ_MSI       = 0;
    localparam int         IRQ_MTI       = 1;
    localparam int         IRQ_MEI       = 2;
    localparam int         IRQ_FIXED     = 3;
endpackage

// *** sim/nmirim_core_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// trap entry, return, mode and masking checks
// ----------------------------------------
module nmirim_core_asserts #(
    parameter int XLEN  = 32,
    parameter int N_IRQ = 6
) (
    input wire logic clk, nrst, nmi_take, mret_exec, cur_mie, cur_mpie,
    input wire logic nmi_vec_sel, redirect, status_wr, new_mie, enh_mode,
    input wire logic irq_to_core,
    input wire logic [1:0] cur_mpp, new_priv, machine_submode_now,
    input wire logic [1:0] machine_submode_prior,
    input wire logic [XLEN-1:0] mepc, mtvec, reset_vector, redirect_pc,
    input wire logic [N_IRQ-1:0] irq_enable, irq_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // nmi wins, so a coincident mret must leave no trace
    logic ret;
    assign ret = mret_exec && !nmi_take;
    a_nmi_vector: assert property (nmi_take |=> redirect &&
        redirect_pc == ($past(nmi_vec_sel) ? $past(mtvec)
        : $past(reset_vector))) else $error("nmi vector wrong");
    a_nmi_submode: assert property (nmi_take |=>
        machine_submode_now == nmirim_pkg::SUBM_NMI &&
        machine_submode_prior == $past(machine_submode_now))
        else $error("nmi sub-mode wrong");
    a_mret_return: assert property (ret |=> redirect && status_wr &&
        redirect_pc == $past(mepc) && new_priv == $past(cur_mpp) &&
        new_mie == $past(cur_mpie)) else $error("mret return wrong");
    a_mret_submode: assert property (ret |=>
        machine_submode_now == $past(machine_submode_prior))
        else $error("mret sub-mode wrong");
    a_redirect_cause: assert property (redirect |->
        $past(nmi_take || mret_exec)) else $error("redirect uncaused");
    a_mode_select: assert property (enh_mode ==
        ($past(mtvec[1:0]) == nmirim_pkg::MODE_CLIC)) else $error("mode wrong");
    a_global_mask: assert property (!cur_mie |=> !irq_to_core)
        else $error("global mask ignored");
    a_pending_gate: assert property (
        !(|(irq_pending & ~$past(irq_enable))))
        else $error("pending not gated");
endmodule
bind nmirim_core nmirim_core_asserts #(.XLEN(XLEN), .N_IRQ(N_IRQ)) u_chk (.*);
`default_nettype wire

// *** sim/nmirim_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// timer unit and interrupt controllers
// ----------------------------------------
module nmirim_far_model #(parameter logic [7:0] CMP = 8'h04) (
    input  wire logic       clk, nrst, set_msw, tmr_on,
    input  wire logic [1:0] ext_src, ext_en,
    input  wire logic [2:0] enh_en,
    output logic            msw_req, timer_req, plat_ext_irq, enh_irq
);
    logic [7:0] cnt;
    // counter saturates so a timer request holds until switched off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            msw_req <= 1'b0;
        end else begin
            msw_req <= set_msw;
            cnt <= !tmr_on ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
        end
    end
    assign timer_req = tmr_on && cnt >= CMP;
    assign plat_ext_irq = |(ext_src & ext_en);
    assign enh_irq = |({|ext_src, timer_req, msw_req} & enh_en);
endmodule
`default_nettype wire

// *** sim/nmirim_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module nmirim_core_tb_top;
    logic clk = 0, nrst = 0, nmi_take = 0, mret_exec = 0, cur_mie = 0;
    logic cur_mpie = 0, nmi_vec_sel = 0, set_msw = 0, tmr_on = 0;
    logic [1:0] cur_priv = 2'h0, cur_mpp = 2'h0, ext_src = 2'h0;
    logic [2:0] enh_en = 3'h0;
    logic [5:0] irq_enable = 6'h00;
    logic [31:0] cur_pc = 32'h80, mepc = 32'h0;
    logic [31:0] mtvec = 32'h100, reset_vector = 32'h200;
    logic redirect, status_wr, new_mie, enh_mode, irq_to_core, msw_req;
    logic timer_req, plat_ext_irq, enh_irq;
    logic [1:0] new_priv, now_m, prior_m;
    logic [31:0] redirect_pc;
    int failures = 0, checked = 0, cycles = 0;
    nmirim_core u_nmirim_core (.*, .new_mpie(), .new_mpp(), .saved_epc(),
        .irq_pending(), .ssw_req(1'b0), .extra_req(2'h0),
        .machine_submode_now(now_m), .machine_submode_prior(prior_m));
    nmirim_far_model u_nmirim_far_model (.*, .ext_en(2'h1));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ev(input logic n, m);
        @(negedge clk);
        nmi_take = n;
        mret_exec = m;
        @(negedge clk);
        nmi_take = 0;
        mret_exec = 0;
    endtask
    // mret raised alongside: the nmi must win
    task automatic t_nmi(input logic s, input logic [1:0] p);
        nmi_vec_sel = s;
        ev(1, 1);
        chk("nmi pc", s ? mtvec : reset_vector, redirect_pc);
        chk("now", nmirim_pkg::SUBM_NMI, now_m);
        chk("prior", p, prior_m);
        chk("priv", nmirim_pkg::PRIV_M, new_priv);
        chk("nmi redirect", 1, redirect);
        chk("nmi status", 1, status_wr);
    endtask
    task automatic t_mret(input logic [1:0] e);
        cur_mpp = 2'h1;
        cur_mpie = 1;
        mepc = 32'h440;
        ev(0, 1);
        chk("mret pc", 32'h440, redirect_pc);
        chk("mret priv", 2'h1, new_priv);
        chk("mret mie", 1, new_mie);
        chk("mret now", e, now_m);
        chk("mret redirect", 1, redirect);
        @(negedge clk);
        chk("redirect off", 0, redirect);
    endtask
    task automatic t_irq(input int i, input int b);
        set_msw = i == 0;
        tmr_on = i == 1;
        ext_src = {1'b0, i == 2};
        cur_mie = 1;
        irq_enable = 6'h01 << b;
        repeat (12) @(negedge clk);
        chk("irq on", 1, irq_to_core);
        irq_enable = 6'h00;
        repeat (12) @(negedge clk);
        chk("irq masked", 0, irq_to_core);
        irq_enable = ~(6'h01 << b);
        repeat (12) @(negedge clk);
        chk("irq other", 0, irq_to_core);
        irq_enable = 6'h01 << b;
        cur_mie = 0;
        repeat (12) @(negedge clk);
        chk("irq global", 0, irq_to_core);
        set_msw = 0;
        tmr_on = 0;
        ext_src = 2'h0;
    endtask
    task automatic t_enh();
        mtvec = 32'h103;
        cur_mie = 1;
        irq_enable = 6'h00;
        enh_en = 3'h1;
        set_msw = 1;
        repeat (12) @(negedge clk);
        chk("enh mode", 1, enh_mode);
        chk("enh irq", 1, irq_to_core);
        enh_en = 3'h0;
        repeat (12) @(negedge clk);
        chk("enh off", 0, irq_to_core);
        mtvec = 32'h100;
        set_msw = 0;
        repeat (2) @(negedge clk);
        chk("basic", 0, enh_mode);
    endtask
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1;
        chk("enh reset", 0, enh_mode);
        t_nmi(0, nmirim_pkg::SUBM_NORMAL);
        t_mret(nmirim_pkg::SUBM_NORMAL);
        t_nmi(1, nmirim_pkg::SUBM_NORMAL);
        t_nmi(0, nmirim_pkg::SUBM_NMI);
        t_mret(nmirim_pkg::SUBM_NMI);
        t_irq(0, nmirim_pkg::IRQ_MSI);
        t_irq(1, nmirim_pkg::IRQ_MTI);
        t_irq(2, nmirim_pkg::IRQ_MEI);
        t_enh();
        end_of_test();
    end
endmodule
`default_nettype wire
